// [logic/deac_consts.vh]
/*
 Constants for the data nonvolatile store access controller.
 Assumes one 20 MHz system clock and a CPU special function register port.
*/
// What this block does
// - Five-bit location picks one of 32 bytes
// - Eight-bit data register, read/write, resets zero
// - Read trigger ignored while fetch enable clear
// - Hardware clears read trigger when byte valid
// - Fetched byte held until next operation
// - Write trigger must follow enable next instruction
// - Write trigger ignored while program enable clear
// - Write timed by independent slow timer
// - Hardware clears write trigger when stored
// - Program enable cleared at reset
// - Bank select resets to bank zero
// - Control register at 40h, bank one, indirect
// - Done flag set at each write end
// - Vector needs enable, global enable, stack room
// - Servicing clears done flag and global enable
`ifndef DEAC_CONSTS_VH
`define DEAC_CONSTS_VH

// Direct special function register offsets (decoded in either bank, except that 02h reaches the control register only in bank 1)
`define DEAC_IND_ADDR 8'h02
`define DEAC_BANK_ADDR 8'h04
`define DEAC_LOC_ADDR 8'h10
`define DEAC_DATA_ADDR 8'h11
`define DEAC_IRQ_ADDR 8'h12
// Indirect location of the control register (bank 1)
`define DEAC_CTRL_PTR 8'h40

// Control register fields
`define DEAC_CTRL_FETCH_TRIG 0
`define DEAC_CTRL_FETCH_EN 1
`define DEAC_CTRL_PROG_TRIG 2
`define DEAC_CTRL_PROG_EN 3
`define DEAC_CTRL_RESERVED 7

// Interrupt register fields
`define DEAC_IRQ_GIE 0
`define DEAC_IRQ_DONE_EN 1
`define DEAC_IRQ_DONE_FLAG 2

// Reset values
`define DEAC_RST_BYTE 8'h00
`define DEAC_RST_LOC 5'h00
`define DEAC_RST_BANK 1'b0

// Timing
`define DEAC_CLK_HZ 20000000
`define DEAC_FETCH_CYCLES 3'h4
`define DEAC_TICK_NS 31250
`define DEAC_TICK_DIV ((`DEAC_TICK_NS * (`DEAC_CLK_HZ / 1000000)) / 1000)
`define DEAC_WRITE_TICKS 64

`endif

// [logic/deac_wtimer.v]
/*
 Write cycle timer: a slow tick divided from the system clock counts the
 programming time, independent of instruction timing.
 Assumes start is a one-cycle pulse and not repeated while busy.
*/
`timescale 1ns/1ps
`include "deac_consts.vh"
module deac_wtimer #(
   parameter TICK_DIV = `DEAC_TICK_DIV,
   parameter WRITE_TICKS = `DEAC_WRITE_TICKS
) (
   // Clock and reset
   input wire clk_in,
   input wire reset_in,
   // Control
   input wire start_in,
   output reg busy_out,
   output reg done_out
);
   reg [15:0] div_count;
   reg [15:0] tick_count;
   wire tick;

   // Free running slow tick, unrelated to the write start
   assign tick = (div_count == 16'h0000);

   // Divider
   always @(posedge clk_in) begin
      if (reset_in) begin
         div_count <= 16'h0000;
      end else if (tick) begin
         div_count <= TICK_DIV[15:0] - 16'h0001;
      end else begin
         div_count <= div_count - 16'h0001;
      end
   end

   // Tick counter, done pulse at the last tick
   always @(posedge clk_in) begin
      if (reset_in) begin
         busy_out <= 1'b0;
         done_out <= 1'b0;
         tick_count <= 16'h0000;
      end else begin
         done_out <= 1'b0;
         if (start_in && !busy_out) begin
            busy_out <= 1'b1;
            tick_count <= WRITE_TICKS[15:0];
         end else if (busy_out && tick) begin
            if (tick_count == 16'h0001) begin
               busy_out <= 1'b0;
               done_out <= 1'b1;
            end
            tick_count <= tick_count - 16'h0001;
         end
      end
   end
endmodule // deac_wtimer

// [logic/deac_ctrl.v]
/*
 Data nonvolatile store access controller: location, data, control,
 bank select and interrupt registers, a 32-byte array, fetch and
 program sequencing and the write-done interrupt request.
 Assumes the CPU presents one register access per clock, marks each
 instruction boundary with instr_step_in, and gives the memory pointer
 value on mp_in for indirect accesses.
*/
`timescale 1ns/1ps
`include "deac_consts.vh"
module deac_ctrl #(
   parameter TICK_DIV = `DEAC_TICK_DIV,
   parameter WRITE_TICKS = `DEAC_WRITE_TICKS
) (
   // Clock and reset
   input wire clk_in,
   input wire reset_in,
   // CPU register port
   input wire [7:0] sfr_addr_in,
   input wire [7:0] mp_in,
   input wire sfr_wr_in,
   input wire sfr_rd_in,
   input wire [7:0] sfr_wdata_in,
   output reg [7:0] sfr_rdata_out,
   input wire instr_step_in,
   // Interrupt
   input wire stack_full_in,
   input wire irq_ack_in,
   output wire irq_vector_out,
   // Status
   output wire busy_out
);
   localparam ST_IDLE = 3'b001;
   localparam ST_FETCH = 3'b010;
   localparam ST_PROGRAM = 3'b100;

   reg [7:0] nvm_array [0:31];
   reg [4:0] nvm_location;
   reg [7:0] nvm_byte_data;
   reg fetch_enable;
   reg fetch_trig;
   reg program_enable;
   reg prog_trig;
   reg bank_select;
   reg global_irq_enable;
   reg nvm_done_irq_enable;
   reg nvm_done_flag;
   reg enable_fresh;
   reg [2:0] state;
   reg [2:0] fetch_count;
   reg [4:0] op_loc;
   reg [7:0] op_byte;
   reg wt_start;
   wire wt_busy;
   wire wt_done;
   wire [7:0] ctrl_value;
   wire wr_loc;
   wire wr_data;
   wire wr_bank;
   wire wr_irq;
   wire wr_ctrl;
   wire rd_ctrl;
   wire want_fetch;
   wire want_prog;
   wire start_fetch;
   wire start_prog;

   // Indirect access decode: control register is at 40h in bank 1
   function is_ctrl;
      input [7:0] addr;
      input [7:0] ptr;
      input bank;
      begin
         is_ctrl = (addr == `DEAC_IND_ADDR) && bank && (ptr == `DEAC_CTRL_PTR);
      end
   endfunction

   assign wr_loc = sfr_wr_in && (sfr_addr_in == `DEAC_LOC_ADDR);
   assign wr_data = sfr_wr_in && (sfr_addr_in == `DEAC_DATA_ADDR);
   assign wr_bank = sfr_wr_in && (sfr_addr_in == `DEAC_BANK_ADDR);
   assign wr_irq = sfr_wr_in && (sfr_addr_in == `DEAC_IRQ_ADDR);
   assign wr_ctrl = sfr_wr_in && is_ctrl(sfr_addr_in, mp_in, bank_select);
   assign rd_ctrl = is_ctrl(sfr_addr_in, mp_in, bank_select);

   // Trigger requests from a control write
   assign want_fetch = wr_ctrl && sfr_wdata_in[`DEAC_CTRL_FETCH_TRIG];
   assign want_prog = wr_ctrl && sfr_wdata_in[`DEAC_CTRL_PROG_TRIG];

   // Fetch needs enable already set; both triggers at once start nothing
   assign start_fetch = want_fetch && !want_prog && fetch_enable && (state == ST_IDLE);
   // Program needs enable set in the instruction just before
   assign start_prog = want_prog && !want_fetch && program_enable && enable_fresh
      && (state == ST_IDLE);

   // Control register image, reserved and unused bits read zero
   assign ctrl_value = {4'h0, program_enable, prog_trig, fetch_enable, fetch_trig};

   // Write-done vector request
   assign irq_vector_out = nvm_done_flag && nvm_done_irq_enable
      && global_irq_enable && !stack_full_in;
   assign busy_out = (state != ST_IDLE);

   // Write cycle timer
   deac_wtimer #(
      .TICK_DIV(TICK_DIV),
      .WRITE_TICKS(WRITE_TICKS)
   ) u_wtimer (
      .clk_in(clk_in),
      .reset_in(reset_in),
      .start_in(wt_start),
      .busy_out(wt_busy),
      .done_out(wt_done)
   );

   // Location and bank select registers
   always @(posedge clk_in) begin
      if (reset_in) begin
         nvm_location <= `DEAC_RST_LOC;
         bank_select <= `DEAC_RST_BANK;
      end else begin
         if (wr_loc) begin
            nvm_location <= sfr_wdata_in[4:0];
         end
         if (wr_bank) begin
            bank_select <= sfr_wdata_in[0];
         end
      end
   end

   // Control enables; program enable cleared at reset
   always @(posedge clk_in) begin
      if (reset_in) begin
         fetch_enable <= 1'b0;
         program_enable <= 1'b0;
      end else if (wr_ctrl) begin
         fetch_enable <= sfr_wdata_in[`DEAC_CTRL_FETCH_EN];
         program_enable <= sfr_wdata_in[`DEAC_CTRL_PROG_EN];
      end
   end

   // Marks that the enable was set in the previous instruction
   always @(posedge clk_in) begin
      if (reset_in) begin
         enable_fresh <= 1'b0;
      end else if (wr_ctrl && sfr_wdata_in[`DEAC_CTRL_PROG_EN] && !sfr_wdata_in[`DEAC_CTRL_PROG_TRIG]) begin
         enable_fresh <= 1'b1;
      end else if (instr_step_in || sfr_wr_in) begin
         enable_fresh <= 1'b0;
      end
   end

   // Sequencer, triggers and data register
   always @(posedge clk_in) begin
      if (reset_in) begin
         state <= ST_IDLE;
         fetch_trig <= 1'b0;
         prog_trig <= 1'b0;
         fetch_count <= 3'h0;
         op_loc <= 5'h00;
         op_byte <= 8'h00;
         wt_start <= 1'b0;
         nvm_byte_data <= `DEAC_RST_BYTE;
      end else begin
         wt_start <= 1'b0;
         if (wr_data && state != ST_FETCH) begin
            nvm_byte_data <= sfr_wdata_in;
         end
         case (state)
            ST_IDLE: begin
               if (start_fetch) begin
                  fetch_trig <= 1'b1;
                  op_loc <= nvm_location;
                  fetch_count <= `DEAC_FETCH_CYCLES;
                  state <= ST_FETCH;
               end else if (start_prog) begin
                  prog_trig <= 1'b1;
                  op_loc <= nvm_location;
                  op_byte <= wr_data ? sfr_wdata_in : nvm_byte_data;
                  wt_start <= 1'b1;
                  state <= ST_PROGRAM;
               end
            end
            ST_FETCH: begin
               if (fetch_count == 3'h1) begin
                  nvm_byte_data <= nvm_array[op_loc];
                  fetch_trig <= 1'b0;
                  state <= ST_IDLE;
               end
               fetch_count <= fetch_count - 3'h1;
            end
            ST_PROGRAM: begin
               if (wt_done) begin
                  prog_trig <= 1'b0;
                  state <= ST_IDLE;
               end
            end
            default: begin
               state <= ST_IDLE;
            end
         endcase
      end
   end

   // Array store at the end of the timed write
   always @(posedge clk_in) begin
      if (state == ST_PROGRAM && wt_done) begin
         nvm_array[op_loc] <= op_byte;
      end
   end

   // Interrupt enables and done flag; a new set beats a clear, except that service beats a CPU write setting the done flag
   always @(posedge clk_in) begin
      if (reset_in) begin
         global_irq_enable <= 1'b0;
         nvm_done_irq_enable <= 1'b0;
         nvm_done_flag <= 1'b0;
      end else begin
         if (wr_irq) begin
            global_irq_enable <= sfr_wdata_in[`DEAC_IRQ_GIE];
            nvm_done_irq_enable <= sfr_wdata_in[`DEAC_IRQ_DONE_EN];
         end else if (irq_ack_in) begin
            global_irq_enable <= 1'b0;
         end
         if (state == ST_PROGRAM && wt_done) begin
            nvm_done_flag <= 1'b1;
         end else if (irq_ack_in) begin
            nvm_done_flag <= 1'b0;
         end else if (wr_irq) begin
            nvm_done_flag <= sfr_wdata_in[`DEAC_IRQ_DONE_FLAG];
         end
      end
   end

   // Registered read data
   always @(posedge clk_in) begin
      if (reset_in) begin
         sfr_rdata_out <= 8'h00;
      end else if (sfr_rd_in) begin
         if (sfr_addr_in == `DEAC_LOC_ADDR) begin
            sfr_rdata_out <= {3'h0, nvm_location};
         end else if (sfr_addr_in == `DEAC_DATA_ADDR) begin
            sfr_rdata_out <= nvm_byte_data;
         end else if (sfr_addr_in == `DEAC_BANK_ADDR) begin
            sfr_rdata_out <= {7'h00, bank_select};
         end else if (sfr_addr_in == `DEAC_IRQ_ADDR) begin
            sfr_rdata_out <= {5'h00, nvm_done_flag, nvm_done_irq_enable, global_irq_enable};
         end else if (rd_ctrl) begin
            sfr_rdata_out <= ctrl_value;
         end else begin
            sfr_rdata_out <= 8'h00;
         end
      end
   end
endmodule // deac_ctrl

// [sim/deac_ctrl_assertions.sv]
/* Port checker for the access controller.
 Bound to deac_ctrl from the bench; sees only its ports. */
`timescale 1ns/1ps
`include "deac_consts.vh"
module deac_ctrl_assertions #(
   parameter TICK_DIV = `DEAC_TICK_DIV,
   parameter WRITE_TICKS = `DEAC_WRITE_TICKS
) (
   // Watched ports
   input wire logic clk_in,
   input wire logic reset_in,
   input wire logic [7:0] sfr_addr_in,
   input wire logic [7:0] mp_in,
   input wire logic sfr_wr_in,
   input wire logic sfr_rd_in,
   input wire logic [7:0] sfr_wdata_in,
   input wire logic [7:0] sfr_rdata_out,
   input wire logic instr_step_in,
   input wire logic stack_full_in,
   input wire logic irq_ack_in,
   input wire logic irq_vector_out,
   input wire logic busy_out
);
   // Longest busy stretch: write ticks plus free tick phase
   localparam int BUSY_MAX = TICK_DIV * (WRITE_TICKS + 1) + 8;
   int busy_len;
   wire logic ctrl_wr = sfr_wr_in && sfr_addr_in == 8'h02;
   wire logic mapped = sfr_addr_in inside {8'h02, 8'h04, 8'h10, 8'h11, 8'h12};
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (reset_in);
   // Length of the current busy stretch
   always @(posedge clk_in) begin
      if (reset_in || !busy_out) busy_len <= 0;
      else busy_len <= busy_len + 1;
   end
   a_reset_clears: assert property (disable iff (1'b0) reset_in |=> sfr_rdata_out == 8'h00 && !busy_out)
      else $error("outputs not cleared by reset");
   a_rdata_holds: assert property (!$past(sfr_rd_in) && !$past(reset_in) |-> $stable(sfr_rdata_out))
      else $error("read data moved without a read");
   a_unmapped_zero: assert property (sfr_rd_in && !mapped |=> sfr_rdata_out == 8'h00)
      else $error("unmapped read not zero");
   a_ctrl_upper_zero: assert property (sfr_rd_in && sfr_addr_in == 8'h02 |=> sfr_rdata_out[6:4] == 3'h0)
      else $error("unimplemented control bits not zero");
   a_busy_cause: assert property ($rose(busy_out) |-> $past(ctrl_wr))
      else $error("busy without a control write");
   a_busy_bounded: assert property (busy_len <= BUSY_MAX)
      else $error("operation never ends");
   a_both_triggers: assert property (ctrl_wr && sfr_wdata_in[0] && sfr_wdata_in[2] && !busy_out |=> !busy_out)
      else $error("both triggers started a cycle");
   a_step_gap: assert property (ctrl_wr && sfr_wdata_in == 8'h0c && $past(instr_step_in)
         && !busy_out |=> !busy_out)
      else $error("write started after a gap");
   a_stack_blocks: assert property (stack_full_in |-> !irq_vector_out)
      else $error("vector with full stack");
   a_ack_drops: assert property (irq_ack_in && !(sfr_wr_in && sfr_addr_in == 8'h12) |=> !irq_vector_out)
      else $error("vector stays after service");
endmodule // deac_ctrl_assertions

// [sim/deac_ctrl_bench.sv]
/* Self-checking bench for the access controller.
 Drives the register port at falling edges; the checker is bound below. */
`timescale 1ns/1ps
`include "deac_consts.vh"
module deac_ctrl_bench;
   // Shortened write timing and register offsets
   localparam TD = 4;
   localparam WT = 3;
   localparam [7:0] IND = `DEAC_IND_ADDR;
   localparam [7:0] LOC = `DEAC_LOC_ADDR;
   localparam [7:0] DAT = `DEAC_DATA_ADDR;
   localparam [7:0] IRQ = `DEAC_IRQ_ADDR;
   reg clk_in = 1'b0;
   reg reset_in = 1'b1;
   reg [7:0] sfr_addr_in = 8'h00;
   reg [7:0] mp_in = `DEAC_CTRL_PTR;
   reg sfr_wr_in = 1'b0;
   reg sfr_rd_in = 1'b0;
   reg [7:0] sfr_wdata_in = 8'h00;
   reg instr_step_in = 1'b0;
   reg stack_full_in = 1'b0;
   reg irq_ack_in = 1'b0;
   wire [7:0] sfr_rdata_out;
   wire irq_vector_out;
   wire busy_out;
   reg [7:0] mem [0:31];
   reg [7:0] loc;
   reg [7:0] dat;
   integer fail_count = 0;
   integer n_tests = 0;
   integer cycles = 0;
   integer i;
   deac_ctrl #(.TICK_DIV(TD), .WRITE_TICKS(WT)) deac_ctrl_i (.clk_in(clk_in), .reset_in(reset_in),
      .sfr_addr_in(sfr_addr_in), .mp_in(mp_in), .sfr_wr_in(sfr_wr_in), .sfr_rd_in(sfr_rd_in),
      .sfr_wdata_in(sfr_wdata_in), .sfr_rdata_out(sfr_rdata_out), .instr_step_in(instr_step_in),
      .stack_full_in(stack_full_in), .irq_ack_in(irq_ack_in), .irq_vector_out(irq_vector_out),
      .busy_out(busy_out));
   // Clock and hang guard
   always #25 clk_in = ~clk_in;
   always @(posedge clk_in) begin
      cycles = cycles + 1;
      if (cycles == 20000) begin
         fail_count = fail_count + 1;
         end_sim;
      end
   end
   // Control readback: triggers clear, enables stay, top nibble zero
   function [7:0] ctrl_exp(input [7:0] w);
      ctrl_exp = w & 8'h0a;
   endfunction
   task end_sim;
      begin
         $display("Mismatches %0d in %0d checks", fail_count, n_tests);
         if (fail_count == 0 && n_tests > 0)
            $display("Run complete: PASS");
         else
            $display("Run complete: FAIL");
         $finish;
      end
   endtask
   task chk(input [7:0] got, input [7:0] exp);
      begin
         n_tests = n_tests + 1;
         if (got !== exp) begin
            fail_count = fail_count + 1;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
         end
      end
   endtask
   // One bus cycle, driven at the falling edge
   task bus(input w, input r, input s, input [7:0] a, input [7:0] d);
      begin
         @(negedge clk_in);
         sfr_wr_in = w;
         sfr_rd_in = r;
         instr_step_in = s;
         sfr_addr_in = a;
         sfr_wdata_in = d;
      end
   endtask
   task idle;
      bus(1'b0, 1'b0, 1'b0, 8'h00, 8'h00);
   endtask
   task rd(input [7:0] a, input [7:0] exp);
      begin
         bus(1'b0, 1'b1, 1'b0, a, 8'h00);
         idle;
         chk(sfr_rdata_out, exp);
      end
   endtask
   // Busy must rise at once, then fall within a bounded wait
   task run_op;
      integer k;
      begin
         idle;
         chk(busy_out, 8'h01);
         for (k = 0; k < 40 && busy_out !== 1'b0; k = k + 1)
            idle;
         chk(busy_out, 8'h00);
      end
   endtask
   // Location, data, then enable and trigger back to back
   task prog_start(input [7:0] l, input [7:0] d);
      begin
         bus(1'b1, 1'b0, 1'b0, LOC, l);
         bus(1'b1, 1'b0, 1'b0, DAT, d);
         bus(1'b1, 1'b0, 1'b0, IND, 8'h08);
         bus(1'b1, 1'b0, 1'b0, IND, 8'h0c);
      end
   endtask
   task prog(input [7:0] l, input [7:0] d);
      begin
         prog_start(l, d);
         run_op;
      end
   endtask
   task fetch(input [7:0] l);
      begin
         bus(1'b1, 1'b0, 1'b0, LOC, l);
         bus(1'b1, 1'b0, 1'b0, IND, 8'h02);
         bus(1'b1, 1'b0, 1'b0, IND, 8'h03);
         run_op;
      end
   endtask
   // Control write that must not start anything
   task refuse(input [7:0] pre, input s, input [7:0] v);
      begin
         bus(1'b1, 1'b0, 1'b0, IND, pre);
         if (s)
            bus(1'b0, 1'b0, 1'b1, 8'h00, 8'h00);
         bus(1'b1, 1'b0, 1'b0, IND, v);
         idle;
         chk(busy_out, 8'h00);
         rd(IND, ctrl_exp(v));
      end
   endtask
   // Main sequence
   initial begin
      dat = $urandom(32'hf0be31ef);
      repeat (6) @(negedge clk_in);
      reset_in = 1'b0;
      rd(DAT, `DEAC_RST_BYTE);
      rd(LOC, 8'h00);
      rd(`DEAC_BANK_ADDR, 8'h00);
      rd(IND, 8'h00);
      bus(1'b1, 1'b0, 1'b0, `DEAC_BANK_ADDR, 8'h01);
      rd(IND, 8'h00);
      rd(8'h33, 8'h00);
      mp_in = 8'h41;
      rd(IND, 8'h00);
      mp_in = `DEAC_CTRL_PTR;
      refuse(8'h00, 1'b0, 8'h01);
      refuse(8'h00, 1'b0, 8'h03);
      refuse(8'h00, 1'b0, 8'h04);
      refuse(8'h00, 1'b0, 8'h0c);
      refuse(8'h08, 1'b1, 8'h0c);
      refuse(8'h0a, 1'b0, 8'h0f);
      refuse(8'h00, 1'b0, 8'hf0);
      for (i = 0; i < 5; i = i + 1) begin
         loc = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : $urandom;
         dat = $urandom;
         mem[loc[4:0]] = dat;
         prog(loc, dat);
         rd(IND, 8'h08);
         rd(IRQ, 8'h04);
         bus(1'b1, 1'b0, 1'b0, IRQ, 8'h00);
         bus(1'b1, 1'b0, 1'b0, DAT, ~dat);
         fetch(loc);
         rd(IND, 8'h02);
         rd(LOC, loc & 8'h1f);
         rd(DAT, dat);
         rd(IRQ, 8'h00);
      end
      fetch(8'h00);
      rd(DAT, mem[0]);
      bus(1'b1, 1'b0, 1'b0, IRQ, 8'h02);
      prog_start(8'h07, 8'h5a);
      bus(1'b1, 1'b0, 1'b0, IRQ, 8'h03);
      run_op;
      chk(irq_vector_out, 8'h01);
      stack_full_in = 1'b1;
      #1 chk(irq_vector_out, 8'h00);
      stack_full_in = 1'b0;
      irq_ack_in = 1'b1;
      idle;
      irq_ack_in = 1'b0;
      chk(irq_vector_out, 8'h00);
      rd(IRQ, 8'h02);
      end_sim;
   end
endmodule // deac_ctrl_bench
bind deac_ctrl deac_ctrl_assertions #(.TICK_DIV(TICK_DIV), .WRITE_TICKS(WRITE_TICKS)) deac_ctrl_assertions_i (
   .clk_in(clk_in), .reset_in(reset_in), .sfr_addr_in(sfr_addr_in), .mp_in(mp_in), .sfr_wr_in(sfr_wr_in),
   .sfr_rd_in(sfr_rd_in), .sfr_wdata_in(sfr_wdata_in), .sfr_rdata_out(sfr_rdata_out),
   .instr_step_in(instr_step_in), .stack_full_in(stack_full_in), .irq_ack_in(irq_ack_in),
   .irq_vector_out(irq_vector_out), .busy_out(busy_out));
